// >>> rtl/tfr_defines.vh
`ifndef TFR_DEFINES_VH
`define TFR_DEFINES_VH

// Command codes, one data byte each
`define TFR_CMD_EXT_OT 8'h50
`define TFR_CMD_EXT_UT 8'h54
`define TFR_CMD_DIE_OT 8'hD6

// Reset values
`define TFR_EXT_OT_RST 8'hB8
`define TFR_EXT_UT_RST 8'hB8
`define TFR_DIE_OT_RST 8'hC0

// Field positions in a response byte
`define TFR_RESP_HI 7
`define TFR_RESP_LO 6
`define TFR_RETRY_HI 5
`define TFR_RETRY_LO 3
`define TFR_DELAY_HI 2
`define TFR_DELAY_LO 0

// Response and retry encodings
`define TFR_RESP_CONT 2'h0
`define TFR_RESP_SHUT 2'h2
`define TFR_RESP_HOLD 2'h3
`define TFR_RETRY_NONE 3'h0
`define TFR_RETRY_ALWAYS 3'h7

// Synchroniser bit positions
`define TFR_S_DIE 0
`define TFR_S_OT 1
`define TFR_S_UT 3
`define TFR_S_RUN 5
`define TFR_S_W 7

// Retry interval unit and derived cycle count
`define TFR_CLK_KHZ 10000
`define TFR_TICK_TIME_MS 1
`define TFR_TICK_CYCLES 14'h2710

`endif

// >>> rtl/tfr_temp_fault_response.v
`timescale 1ns/1ns
`include "tfr_defines.vh"

// Functional notes
// RQ1: A die overtemperature response write with code 00 or 01 is refused and raises the CML fault.
// RQ2: Die response code 10 disables the output at once and then follows the retry field.
// RQ3: Die response code 11 holds the output off while the fault is present and releases it afterwards.
// RQ4: Every response code, whatever its value, still sets the matching status flag on a fault.
// RQ5: A die overtemperature fault sets the none-of-the-above, manufacturer and manufacturer OT flags.
// RQ6: Any temperature fault drives the alert line unless its source is masked.
// RQ7: A set fault flag stays until a clear-faults command, an off-then-on of the output, or power cycling; off-then-on leaves the CML flag set.
// RQ8: Retry setting 000 makes no restart and keeps the output off until the fault is cleared.
// RQ9: A die response write with any retry value other than 000 is refused and raises the CML fault.
// RQ10: The delay field in bits 2:0 is stored but never changes behaviour.
// RQ11: The external overtemperature response is a paged one-byte read/write command at 0x50, reset 0xB8.
// RQ12: The external undertemperature response is a paged one-byte read/write command at 0x54, reset 0xB8.
// RQ13: An external overtemperature fault sets the temperature summary flag and the OT temperature flag.
// RQ14: Each of these commands carries exactly one data byte per read or write.
// RQ15: External code 00 keeps running, 10 shuts down then retries as set, 01 and 11 are refused with CML.
// RQ16: External retry 111 restarts repeatedly, one programmed interval apart, until commanded off.
// RQ17: A refused write keeps the old contents, and paged writes reach only the selected channel.
module tfr_temp_fault_response #(
    parameter [13:0] TICK_CYCLES = `TFR_TICK_CYCLES
) (
    input wire mclk,
    input wire rstn,
    input wire cmd_wr,
    input wire cmd_rd,
    input wire [7:0] cmd_code,
    input wire [7:0] cmd_wdata,
    input wire cmd_page,
    output reg [7:0] cmd_rdata,
    output reg cmd_rvalid,
    input wire die_ot_pin,
    input wire [1:0] ext_ot_pin,
    input wire [1:0] ext_ut_pin,
    input wire [1:0] run_pin,
    input wire [1:0] oper_on,
    input wire clear_faults,
    input wire [7:0] restart_interval_setting,
    input wire mask_die,
    input wire mask_ot,
    input wire mask_ut,
    input wire mask_cml,
    output wire [1:0] out_en,
    output reg die_ot_flag_r,
    output wire [1:0] ext_ot_flag,
    output wire [1:0] ext_ut_flag,
    output wire [1:0] temp_summary,
    output wire none_above_flag,
    output wire mfr_word_flag,
    output reg cml_flag_r,
    output wire alert_o,
    output reg alert_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    reg [`TFR_S_W-1:0] sync1_r;
    reg [`TFR_S_W-1:0] sync2_r;
    wire die_f;
    wire [1:0] ot_f;
    wire [1:0] ut_f;
    wire [1:0] run_s;

    // Two stages; first stage feeds only the second
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= 7'h00;
            sync2_r <= 7'h00;
        end else begin
            sync1_r <= {run_pin, ext_ut_pin, ext_ot_pin, die_ot_pin};
            sync2_r <= sync1_r;
        end
    end

    assign die_f = sync2_r[`TFR_S_DIE];
    assign ot_f = sync2_r[`TFR_S_OT+1:`TFR_S_OT];
    assign ut_f = sync2_r[`TFR_S_UT+1:`TFR_S_UT];
    assign run_s = sync2_r[`TFR_S_RUN+1:`TFR_S_RUN];

    ////////////////////////////////////////////////////////////////////////
    // Retry interval tick divider
    reg [13:0] tick_cnt_r;
    wire tick;

    assign tick = (tick_cnt_r == (TICK_CYCLES - 14'h0001));

    // Free running so all channels share one time base
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_r <= 14'h0000;
        end else if (tick) begin
            tick_cnt_r <= 14'h0000;
        end else begin
            tick_cnt_r <= tick_cnt_r + 14'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command decode and write checks
    reg [7:0] die_act_r;
    reg [15:0] ot_act_r;
    reg [15:0] ut_act_r;
    wire [1:0] w_resp;
    wire [2:0] w_retry;
    wire is_die;
    wire is_ot;
    wire is_ut;
    wire die_ok;
    wire ext_ok;
    wire wr_bad;
    wire [3:0] pg_lsb;

    assign w_resp = cmd_wdata[`TFR_RESP_HI:`TFR_RESP_LO];
    assign w_retry = cmd_wdata[`TFR_RETRY_HI:`TFR_RETRY_LO];
    assign is_die = (cmd_code == `TFR_CMD_DIE_OT);
    assign is_ot = (cmd_code == `TFR_CMD_EXT_OT);
    assign is_ut = (cmd_code == `TFR_CMD_EXT_UT);
    assign pg_lsb = {cmd_page, 3'h0};
    // Die response accepts only 10 or 11 with no retry
    assign die_ok = w_resp[1] && (w_retry == `TFR_RETRY_NONE); // RQ1 RQ9
    // External response accepts 00 or 10, retry 000 or 111
    assign ext_ok = ((w_resp == `TFR_RESP_CONT) || (w_resp == `TFR_RESP_SHUT)) &&
                    ((w_retry == `TFR_RETRY_NONE) || (w_retry == `TFR_RETRY_ALWAYS)); // RQ15
    // Unknown codes are refused the same way
    assign wr_bad = cmd_wr && ((is_die && !die_ok) || ((is_ot || is_ut) && !ext_ok) ||
                    !(is_die || is_ot || is_ut)); // RQ1 RQ9 RQ15

    // Response bytes; whole byte written, delay bits kept for read-back only
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            die_act_r <= `TFR_DIE_OT_RST;
            ot_act_r <= {`TFR_EXT_OT_RST, `TFR_EXT_OT_RST}; // RQ11
            ut_act_r <= {`TFR_EXT_UT_RST, `TFR_EXT_UT_RST}; // RQ12
        end else if (cmd_wr && !wr_bad) begin
            if (is_die) begin
                die_act_r <= cmd_wdata; // RQ10 RQ14
            end
            if (is_ot) begin
                ot_act_r[pg_lsb +: 8] <= cmd_wdata; // RQ11 RQ17
            end
            if (is_ut) begin
                ut_act_r[pg_lsb +: 8] <= cmd_wdata; // RQ12 RQ17
            end
        end
    end

    // Read answer one cycle after the strobe
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cmd_rdata <= 8'h00;
            cmd_rvalid <= 1'b0;
        end else begin
            cmd_rvalid <= cmd_rd; // RQ14
            if (cmd_rd) begin
                if (is_die) begin
                    cmd_rdata <= die_act_r;
                end else if (is_ot) begin
                    cmd_rdata <= ot_act_r[pg_lsb +: 8]; // RQ11
                end else if (is_ut) begin
                    cmd_rdata <= ut_act_r[pg_lsb +: 8]; // RQ12
                end else begin
                    cmd_rdata <= 8'h00;
                end
            end
        end
    end

    // CML flag; a new refusal wins over a clear in the same cycle
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cml_flag_r <= 1'b0;
        end else if (wr_bad) begin
            cml_flag_r <= 1'b1; // RQ1 RQ9 RQ17
        end else if (clear_faults) begin
            cml_flag_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel response engine
    wire [1:0] on_rise;
    wire [1:0] die_resp;
    wire die_shut;
    wire die_hold;

    assign die_resp = die_act_r[`TFR_RESP_HI:`TFR_RESP_LO];
    assign die_shut = die_f && (die_resp == `TFR_RESP_SHUT); // RQ2
    assign die_hold = die_f && (die_resp == `TFR_RESP_HOLD); // RQ3

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_ch
            wire [7:0] ot_a;
            wire [7:0] ut_a;
            wire on;
            wire ot_shut;
            wire ut_shut;
            wire latch_trig;
            wire retry_trig;
            wire cnt_done;
            reg on_prev_r;
            reg latch_r;
            reg wait_r;
            reg [7:0] cnt_r;
            reg en_r;
            reg ot_flag_r;
            reg ut_flag_r;

            assign ot_a = ot_act_r[8*g+7:8*g];
            assign ut_a = ut_act_r[8*g+7:8*g];
            assign on = run_s[g] && oper_on[g];
            assign on_rise[g] = on && !on_prev_r;
            // Code 00 never shuts down; only 10 does
            assign ot_shut = ot_f[g] && (ot_a[`TFR_RESP_HI:`TFR_RESP_LO] == `TFR_RESP_SHUT); // RQ15
            assign ut_shut = ut_f[g] && (ut_a[`TFR_RESP_HI:`TFR_RESP_LO] == `TFR_RESP_SHUT); // RQ15
            assign latch_trig = die_shut ||
                (ot_shut && (ot_a[`TFR_RETRY_HI:`TFR_RETRY_LO] == `TFR_RETRY_NONE)) ||
                (ut_shut && (ut_a[`TFR_RETRY_HI:`TFR_RETRY_LO] == `TFR_RETRY_NONE)); // RQ2 RQ8
            assign retry_trig =
                (ot_shut && (ot_a[`TFR_RETRY_HI:`TFR_RETRY_LO] == `TFR_RETRY_ALWAYS)) ||
                (ut_shut && (ut_a[`TFR_RETRY_HI:`TFR_RETRY_LO] == `TFR_RETRY_ALWAYS)); // RQ16
            // Setting of zero still waits one tick, never a zero-length retry
            assign cnt_done = (cnt_r + 8'h01 >= restart_interval_setting);

            // Shutdown latch and retry wait; both drop when commanded off
            always @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    on_prev_r <= 1'b0;
                    latch_r <= 1'b0;
                    wait_r <= 1'b0;
                    cnt_r <= 8'h00;
                    en_r <= 1'b0;
                end else begin
                    on_prev_r <= on;
                    if (!on) begin
                        latch_r <= 1'b0;
                        wait_r <= 1'b0;
                        cnt_r <= 8'h00;
                    end else begin
                        if (latch_trig) begin
                            latch_r <= 1'b1; // RQ8
                        end else if (clear_faults) begin
                            latch_r <= 1'b0; // RQ8
                        end
                        if (wait_r) begin
                            if (tick && cnt_done) begin
                                wait_r <= 1'b0; // RQ16
                                cnt_r <= 8'h00;
                            end else if (tick) begin
                                cnt_r <= cnt_r + 8'h01;
                            end
                        end else if (retry_trig) begin
                            wait_r <= 1'b1; // RQ16
                            cnt_r <= 8'h00;
                        end
                    end
                    // Drops the cycle after a trigger; hold tracks the fault level
                    en_r <= on && !latch_r && !wait_r && !latch_trig && !retry_trig && !die_hold; // RQ2 RQ3
                end
            end

            // External flags; a fault present wins over any clear
            always @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    ot_flag_r <= 1'b0;
                    ut_flag_r <= 1'b0;
                end else begin
                    if (ot_f[g]) begin
                        ot_flag_r <= 1'b1; // RQ4 RQ13
                    end else if (clear_faults || on_rise[g]) begin
                        ot_flag_r <= 1'b0; // RQ7
                    end
                    if (ut_f[g]) begin
                        ut_flag_r <= 1'b1; // RQ4
                    end else if (clear_faults || on_rise[g]) begin
                        ut_flag_r <= 1'b0; // RQ7
                    end
                end
            end

            assign out_en[g] = en_r;
            assign ext_ot_flag[g] = ot_flag_r;
            assign ext_ut_flag[g] = ut_flag_r;
            assign temp_summary[g] = ot_flag_r || ut_flag_r; // RQ13
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Die flag, shared by both channels
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            die_ot_flag_r <= 1'b0;
        end else if (die_f) begin
            die_ot_flag_r <= 1'b1; // RQ4 RQ5
        end else if (clear_faults || (|on_rise)) begin
            die_ot_flag_r <= 1'b0; // RQ7
        end
    end

    assign none_above_flag = die_ot_flag_r; // RQ5
    assign mfr_word_flag = die_ot_flag_r; // RQ5

    ////////////////////////////////////////////////////////////////////////
    // Alert, open-drain: pulled low while enable is high
    assign alert_o = 1'b0;

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            alert_oe <= 1'b0;
        end else begin
            alert_oe <= (die_ot_flag_r && !mask_die) || ((|ext_ot_flag) && !mask_ot) ||
                        ((|ext_ut_flag) && !mask_ut) || (cml_flag_r && !mask_cml); // RQ6
        end
    end

endmodule // tfr_temp_fault_response

// >>> verif/tfr_temp_fault_response_assertions.sv
`timescale 1ns/1ns
// Watches the command port and the status outputs
module tfr_checker (
    input wire mclk,
    input wire rstn,
    input wire cmd_wr,
    input wire cmd_rd,
    input wire [7:0] cmd_code,
    input wire [7:0] cmd_wdata,
    input wire die_ot_pin,
    input wire mask_cml,
    input wire clear_faults,
    input wire cmd_rvalid,
    input wire die_ot_flag_r,
    input wire [1:0] ext_ot_flag,
    input wire [1:0] ext_ut_flag,
    input wire [1:0] temp_summary,
    input wire none_above_flag,
    input wire mfr_word_flag,
    input wire cml_flag_r,
    input wire alert_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////
    // Die writes and a die fault held past the two-stage sync
    sequence s_die_wr;
        cmd_wr && cmd_code == 8'hD6;
    endsequence
    sequence s_die_hot;
        die_ot_pin [*5];
    endsequence
    a_die_resp_bad: assert property (s_die_wr ##0 !cmd_wdata[7] |=> cml_flag_r)
        else $error("die code 00/01 not refused");
    a_die_retry_bad: assert property (s_die_wr ##0 cmd_wdata[5:3] != 3'h0 |=> cml_flag_r)
        else $error("die retry not refused");
    a_ext_resp_bad: assert property (cmd_wr && cmd_wdata[6] && (cmd_code == 8'h50 || cmd_code == 8'h54)
        |=> cml_flag_r)
        else $error("ext code 01/11 not refused");
    a_die_flag_set: assert property (s_die_hot |-> die_ot_flag_r)
        else $error("die flag missing");
    a_die_copies: assert property (none_above_flag == die_ot_flag_r && mfr_word_flag == die_ot_flag_r)
        else $error("die summary copies wrong");
    a_temp_summary: assert property (temp_summary == (ext_ot_flag | ext_ut_flag))
        else $error("temperature summary wrong");
    a_cml_alert: assert property (cml_flag_r && !mask_cml |-> ##[0:2] alert_oe)
        else $error("alert missing");
    a_cml_sticky: assert property ($fell(cml_flag_r) |-> $past(clear_faults))
        else $error("cml flag dropped");
    a_rd_answer: assert property (cmd_rd |=> cmd_rvalid)
        else $error("read unanswered");
endmodule // tfr_checker

// >>> verif/tfr_host_model.sv
`timescale 1ns/1ns
// Host side: one strobe cycle per access, one byte each
module tfr_host_model (
    input wire mclk,
    output logic cmd_wr,
    output logic cmd_rd,
    output logic [7:0] cmd_code,
    output logic [7:0] cmd_wdata,
    output logic cmd_page
);
    initial begin
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 8'h00;
        cmd_page = 1'b0;
    end
    // Idle lines show the inverse so stale bytes never look valid
    task automatic xfer(input bit w, input logic [7:0] c, input logic p, input logic [7:0] d);
        @(posedge mclk);
        #1;
        cmd_wr = w;
        cmd_rd = !w;
        cmd_code = c;
        cmd_page = p;
        cmd_wdata = d;
        @(posedge mclk);
        #1;
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_code = ~c;
        cmd_wdata = ~d;
    endtask
endmodule // tfr_host_model

// >>> verif/tb_temperature_fault_response.sv
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module tb_temperature_fault_response;
    logic mclk, rstn, clear_faults, die_ot_pin, mask_die, mask_ot, mask_ut, mask_cml;
    logic cmd_wr, cmd_rd, cmd_page, cmd_rvalid, die_ot_flag_r, none_above_flag, mfr_word_flag, cml_flag_r, alert_oe;
    logic [7:0] cmd_code, cmd_wdata, cmd_rdata, r, exp_b, restart_interval_setting;
    logic [1:0] ext_ot_pin, ext_ut_pin, run_pin, oper_on, out_en, ext_ot_flag, ext_ut_flag, temp_summary;
    logic [7:0] exp_q[$];
    logic [15:0] bad[6] = '{16'hD600, 16'hD640, 16'hD6C8, 16'h5040, 16'h54C0, 16'h5090};
    int failures = 0;
    int cmp_count = 0;
    // Short tick keeps the retry wait to a few dozen cycles
    tfr_temp_fault_response #(.TICK_CYCLES(14'h0008)) u_tfr_temp_fault_response (.*, .alert_o());
    tfr_host_model u_tfr_host_model (.*);
    ////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Read answers pair with the oldest expected byte; own variable so stimulus bytes are never overwritten
    always begin
        @(posedge mclk);
        #2;
        if (cmd_rvalid === 1'b1) begin
            exp_b = exp_q.pop_front();
            `CHK(cmd_rdata, exp_b)
        end
    end
    task close_out;
        if (failures == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task rd(input logic [7:0] c, input logic p, input logic [7:0] e);
        exp_q.push_back(e);
        u_tfr_host_model.xfer(1'b0, c, p, 8'h00);
    endtask
    task wr(input logic [7:0] c, input logic p, input logic [7:0] d);
        u_tfr_host_model.xfer(1'b1, c, p, d);
    endtask
    task clr;
        clear_faults = 1'b1;
        wt(1);
        clear_faults = 1'b0;
    endtask
    // Bounded wait for a channel to come back on
    task until_on(input int b);
        int k;
        for (k = 0; k < 200 && out_en[b] !== 1'b1; k++)
            wt(1);
        if (k == 200) begin
            failures++;
            close_out;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(35475));
        {rstn, clear_faults, die_ot_pin, mask_die, mask_ot, mask_ut, mask_cml} = 7'h00;
        {ext_ot_pin, ext_ut_pin, run_pin, oper_on} = 8'h0F;
        // Interval of three to five ticks, long enough to see the retry gap
        restart_interval_setting = 8'h03 + 8'($urandom % 3);
        wt(5);
        rstn = 1'b1;
        until_on(0);
        until_on(1);
        rd(8'h50, 1'b0, 8'hB8);
        rd(8'h50, 1'b1, 8'hB8);
        rd(8'h54, 1'b0, 8'hB8);
        rd(8'h54, 1'b1, 8'hB8);
        rd(8'hD6, 1'b0, 8'hC0);
        // Refused writes raise CML and alert
        foreach (bad[i]) begin
            wr(bad[i][15:8], 1'b0, bad[i][7:0]);
            wt(2);
            `CHK(cml_flag_r, 1'b1)
            `CHK(alert_oe, 1'b1)
            clr;
        end
        wt(1);
        `CHK(cml_flag_r, 1'b0)
        rd(8'hD6, 1'b0, 8'hC0);
        rd(8'h54, 1'b0, 8'hB8);
        // Random delay bits are stored but inert
        r = 8'h80 | 8'($urandom % 8);
        wr(8'h50, 1'b1, r);
        rd(8'h50, 1'b1, r);
        rd(8'h50, 1'b0, 8'hB8);
        r = 8'hC0 | 8'($urandom % 8);
        wr(8'hD6, 1'b0, r);
        rd(8'hD6, 1'b0, r);
        // Channel 0 shuts down then restarts by itself
        ext_ot_pin = 2'h1;
        wt(5);
        `CHK(out_en, 2'h2)
        `CHK(ext_ot_flag, 2'h1)
        `CHK(temp_summary, 2'h1)
        `CHK(alert_oe, 1'b1)
        ext_ot_pin = 2'h0;
        wt(10);
        `CHK(out_en[0], 1'b0)
        until_on(0);
        `CHK(ext_ot_flag, 2'h1)
        clr;
        wt(1);
        `CHK(ext_ot_flag, 2'h0)
        // Channel 1 has retry 000: stays off until cleared
        ext_ot_pin = 2'h2;
        wt(5);
        ext_ot_pin = 2'h0;
        wt(40);
        `CHK(out_en, 2'h1)
        clr;
        until_on(1);
        // Die code 11 holds off only while hot
        die_ot_pin = 1'b1;
        wt(5);
        `CHK(out_en, 2'h0)
        `CHK(die_ot_flag_r, 1'b1)
        `CHK({none_above_flag, mfr_word_flag}, 2'h3)
        die_ot_pin = 1'b0;
        until_on(0);
        until_on(1);
        `CHK(die_ot_flag_r, 1'b1)
        clr;
        // Die code 10 retry 000 latches off; off-then-on releases
        wr(8'hD6, 1'b0, 8'h80);
        die_ot_pin = 1'b1;
        wt(5);
        die_ot_pin = 1'b0;
        wt(30);
        `CHK(out_en, 2'h0)
        oper_on = 2'h0;
        wt(3);
        oper_on = 2'h3;
        until_on(0);
        until_on(1);
        `CHK(die_ot_flag_r, 1'b0)
        // Code 00 keeps running; masked source stays quiet
        wr(8'h54, 1'b0, 8'h38);
        mask_ut = 1'b1;
        ext_ut_pin = 2'h1;
        wt(6);
        `CHK(out_en, 2'h3)
        `CHK(ext_ut_flag, 2'h1)
        `CHK(alert_oe, 1'b0)
        wt(4);
        close_out;
    end
endmodule // tb_temperature_fault_response
bind tfr_temp_fault_response tfr_checker u_tfr_checker (.*);
